// ==== hdl/smc_pkg.sv ====
/*
  Shared constants and types for the timer mode/readout slice:
  register byte offsets, field codes, reset values and state structs.
  Assumes a 32-bit AHB-Lite register bus, one aligned word per register.
*/
package smc_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SMC_OFS_CTRL_FIRST  = 8'h00;
  localparam logic [7:0] SMC_OFS_CTRL_SECOND = 8'h04;
  localparam logic [7:0] SMC_OFS_COUNT_LOW   = 8'h08;
  localparam logic [7:0] SMC_OFS_COUNT_HIGH  = 8'h0C;
  localparam logic [7:0] SMC_OFS_COMPARE_A   = 8'h10;
  localparam logic [7:0] SMC_OFS_STATUS      = 8'h14;
  localparam logic [7:0] SMC_OFS_CAPTURE     = 8'h18;

  // ----------------------------------------------------------------
  // field codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SMC_MODE_COMPARE = 2'h0;
  localparam logic [1:0] SMC_MODE_CAPTURE = 2'h1;
  localparam logic [1:0] SMC_MODE_PWM     = 2'h2;
  localparam logic [1:0] SMC_MODE_TIMER   = 2'h3;
  // compare match output pin actions
  localparam logic [1:0] SMC_CMP_NOCHG    = 2'h0;
  localparam logic [1:0] SMC_CMP_LOW      = 2'h1;
  localparam logic [1:0] SMC_CMP_HIGH     = 2'h2;
  localparam logic [1:0] SMC_CMP_TOGGLE   = 2'h3;
  // pwm / single pulse pin functions
  localparam logic [1:0] SMC_PWM_INACTIVE = 2'h0;
  localparam logic [1:0] SMC_PWM_ACTIVE   = 2'h1;
  localparam logic [1:0] SMC_PWM_WAVE     = 2'h2;
  localparam logic [1:0] SMC_PWM_PULSE    = 2'h3;
  // capture edge selections
  localparam logic [1:0] SMC_CAP_RISE     = 2'h0;
  localparam logic [1:0] SMC_CAP_FALL     = 2'h1;
  localparam logic [1:0] SMC_CAP_BOTH     = 2'h2;

  // ----------------------------------------------------------------
  // widths, counts and bus values
  // ----------------------------------------------------------------
  localparam logic [6:0] SMC_P_LOW_ZERO   = 7'h00;  // 128-clock steps
  localparam logic [9:0] SMC_COUNT_ONE    = 10'h001;
  localparam logic [9:0] SMC_COUNT_ZERO   = 10'h000;
  localparam logic [2:0] SMC_HSIZE_WORD   = 3'h2;
  localparam logic       SMC_RESP_OKAY    = 1'b0;
  localparam logic [31:0] SMC_RDATA_ZERO  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // register and state structs
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       pause;
    logic       counter_run;
    logic [2:0] compare_p_value;
  } smc_ctrl_first_t;

  typedef struct packed {
    logic op_mode_sel_hi;
    logic op_mode_sel_lo;
    logic pin_func_sel_hi;
    logic pin_func_sel_lo;
    logic pin_initial_level;
    logic pin_invert;
    logic period_duty_swap;
    logic clear_source_sel;
  } smc_ctrl_second_t;

  typedef struct packed {
    smc_ctrl_first_t  ctrl_first;
    smc_ctrl_second_t control_reg_second;
    logic [9:0]       compare_a_value;
    logic [9:0]       count;
    logic [9:0]       capture_value;
    logic             run_q;
    logic             out_changed;
    logic             out_level;
    logic             match_a_flag;
    logic             match_p_flag;
    logic             capture_flag;
    logic             pin_o;
    logic             pin_oe;
    logic             wr_pend;
    logic [7:0]       wr_addr;
    logic [31:0]      rdata;
  } smc_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic stable;
    logic rise;
    logic fall;
  } smc_sync_t;

  localparam smc_state_t SMC_STATE_RST = '0;
  localparam smc_sync_t  SMC_SYNC_RST  = '0;

endpackage

// ==== hdl/smc_pin_sync.sv ====
/*
  Three-stage synchroniser and edge detector for the timer pin input.
  Assumes the pin is asynchronous to clk; a change is accepted once
  the second and third stages agree.
*/
`timescale 1ns/1ps
`default_nettype none
module smc_pin_sync
  import smc_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic pin_async,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  smc_sync_t st;
  smc_sync_t next_st;

  // shift chain; first stage feeds only the second stage
  always_comb begin
    next_st      = st;
    next_st.s1   = pin_async;
    next_st.s2   = st.s1;
    next_st.s3   = st.s2;
    next_st.rise = (st.s2 == st.s3) & st.s3 & ~st.stable;
    next_st.fall = (st.s2 == st.s3) & ~st.s3 & st.stable;
    if (st.s2 == st.s3) begin
      next_st.stable = st.s3;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= SMC_SYNC_RST;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.stable;
  assign rise  = st.rise;
  assign fall  = st.fall;

endmodule // smc_pin_sync
`default_nettype wire

// ==== hdl/smc_timer.sv ====
/*
  Ten-bit timer with mode/output control and counter readout,
  reached over AHB-Lite.  One pin serves as compare/PWM output or
  capture input.
  Assumes a single master, whole-word single transfers and one clock;
  the counter advances once per SYS_CLK while running.
*/
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - mode field picks compare, capture, PWM, timer
// - compare P sets the match point to P times 128, less one
// - A match: keep, low, high, toggle pin
// - PWM: force inactive, active, wave, pulse
// - capture on rise, fall, both, or off
// - match to same level shows no change
// - run rising edge restores initial pin level
// - initial level bit sets pre-match pin
// - level bit picks PWM active polarity
// - invert bit flips driven pin level
// - swap bit exchanges period and duty sources
// - clear source ignored in PWM and capture
// - low byte reads counter bits seven..zero
// - run rising clears counter; off freezes it
// - only A match changes compare pin
// - high byte reads counter bits nine, eight
module smc_timer
  import smc_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic [31:0]      HRDATA,
  output logic             HRESP,
  input  wire logic        TIMER_IO_PIN_I,
  output logic             TIMER_IO_PIN_O,
  output logic             TIMER_IO_PIN_OE
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // builds the word that a register read returns
  function automatic logic [31:0] read_word(
    input smc_state_t s,
    input logic       pin_lvl,
    input logic [7:0] a
  );
    logic [31:0] w;
    w = SMC_RDATA_ZERO;
    case (a)
      SMC_OFS_CTRL_FIRST: begin
        w[7]   = s.ctrl_first.pause;
        w[3]   = s.ctrl_first.counter_run;
        w[2:0] = s.ctrl_first.compare_p_value;
      end
      SMC_OFS_CTRL_SECOND: begin
        w[7:0] = s.control_reg_second;
      end
      SMC_OFS_COUNT_LOW: begin
        w[7:0] = s.count[7:0];
      end
      SMC_OFS_COUNT_HIGH: begin
        w[1:0] = s.count[9:8];
      end
      SMC_OFS_COMPARE_A: begin
        w[9:0] = s.compare_a_value;
      end
      SMC_OFS_STATUS: begin
        w[3:0] = {pin_lvl, s.capture_flag, s.match_p_flag,
                  s.match_a_flag};
      end
      SMC_OFS_CAPTURE: begin
        w[9:0] = s.capture_value;
      end
      default: begin
        w = SMC_RDATA_ZERO;
      end
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------
  // state and pin input
  // ----------------------------------------------------------------
  smc_state_t st;
  smc_state_t next_st;

  logic pin_level;
  logic pin_rise;
  logic pin_fall;

  smc_pin_sync u_sync (
    .clk       (SYS_CLK),
    .reset     (RESET),
    .pin_async (TIMER_IO_PIN_I),
    .level     (pin_level),
    .rise      (pin_rise),
    .fall      (pin_fall)
  );

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  logic [1:0] mode;
  logic [1:0] func;
  logic       oc;
  logic       cmp_like;
  logic       is_pwm;
  logic       is_pulse;

  // mode and pin function as two-bit codes
  assign mode = {st.control_reg_second.op_mode_sel_hi,
                 st.control_reg_second.op_mode_sel_lo};
  assign func = {st.control_reg_second.pin_func_sel_hi,
                 st.control_reg_second.pin_func_sel_lo};
  assign oc   = st.control_reg_second.pin_initial_level;
  // compare and timer modes share the counting behaviour
  assign cmp_like = (mode == SMC_MODE_COMPARE) |
                    (mode == SMC_MODE_TIMER);
  assign is_pwm   = (mode == SMC_MODE_PWM);
  assign is_pulse = is_pwm & (func == SMC_PWM_PULSE);

  // ----------------------------------------------------------------
  // counter and comparators
  // ----------------------------------------------------------------
  logic       run_rise;
  logic       counting;
  logic [9:0] p_top;
  logic [9:0] p_edge;
  logic       p_hit;
  logic       a_hit;
  logic       clr;

  // run edge taken one cycle after the write lands
  assign run_rise = st.ctrl_first.counter_run & ~st.run_q;
  assign counting = st.ctrl_first.counter_run &
                    ~st.ctrl_first.pause & ~run_rise;
  // P sets only bits 9..7 of p_edge and the match point is one below it, so its points are 128-count steps;
  // a zero setting wraps to 1023, i.e. a plain overflow
  assign p_edge = {st.ctrl_first.compare_p_value, SMC_P_LOW_ZERO};
  assign p_top  = p_edge - SMC_COUNT_ONE;
  assign p_hit  = counting & (st.count == p_top);
  assign a_hit  = counting & (st.count == st.compare_a_value);

  // clear source per mode; single pulse stops instead of clearing
  always_comb begin
    if (cmp_like) begin
      clr = st.control_reg_second.clear_source_sel ?
            a_hit : p_hit;
    end else if (is_pulse) begin
      clr = 1'b0;
    end else if (is_pwm) begin
      clr = st.control_reg_second.period_duty_swap ?
            a_hit : p_hit;
    end else begin
      clr = p_hit;
    end
  end

  // ----------------------------------------------------------------
  // pin output shaping
  // ----------------------------------------------------------------
  logic cmp_level;
  logic cmp_next;
  logic duty_act;
  logic pwm_act;
  logic drive;

  // before any match the pin shows the initial level bit
  assign cmp_level = st.out_changed ? st.out_level : oc;

  // level requested by an A match; equal level shows no change
  always_comb begin
    case (func)
      SMC_CMP_LOW:    cmp_next = 1'b0;
      SMC_CMP_HIGH:   cmp_next = 1'b1;
      SMC_CMP_TOGGLE: cmp_next = ~cmp_level;
      default:        cmp_next = cmp_level;
    endcase
  end

  // duty comes from whichever compare does not set the period
  assign duty_act = st.control_reg_second.period_duty_swap ?
                    (st.count < p_edge) :
                    (st.count < st.compare_a_value);

  // pwm internal waveform keeps running even when forced
  always_comb begin
    case (func)
      SMC_PWM_INACTIVE: pwm_act = 1'b0;
      SMC_PWM_ACTIVE:   pwm_act = 1'b1;
      SMC_PWM_WAVE:     pwm_act = duty_act & st.ctrl_first.counter_run;
      default:          pwm_act = st.ctrl_first.counter_run;
    endcase
  end

  // choose level per mode, then polarity and inversion
  always_comb begin
    if (is_pwm) begin
      drive = pwm_act ? oc : ~oc;
    end else begin
      drive = cmp_level;
    end
  end

  // ----------------------------------------------------------------
  // capture and bus decode
  // ----------------------------------------------------------------
  logic cap_evt;
  logic ap;
  logic wr_ok;
  logic [2:0] flag_clr;

  // edge select; code 11 disables capture
  always_comb begin
    cap_evt = 1'b0;
    if ((mode == SMC_MODE_CAPTURE) & st.ctrl_first.counter_run) begin
      case (func)
        SMC_CAP_RISE: cap_evt = pin_rise;
        SMC_CAP_FALL: cap_evt = pin_fall;
        SMC_CAP_BOTH: cap_evt = pin_rise | pin_fall;
        default:      cap_evt = 1'b0;
      endcase
    end
  end

  // address phase accepted on any valid transfer, zero wait
  assign ap    = HSEL & HTRANS[1] & HREADY;
  assign wr_ok = ap & HWRITE & (HSIZE == SMC_HSIZE_WORD);
  // write-one-to-clear mask for the status flags
  assign flag_clr = (st.wr_pend & (st.wr_addr == SMC_OFS_STATUS)) ?
                    HWDATA[2:0] : 3'h0;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.run_q = st.ctrl_first.counter_run;

    // counter: clear on run edge, hold when off or paused
    if (run_rise) begin
      next_st.count = SMC_COUNT_ZERO;
    end else if (counting) begin
      if (clr) begin
        next_st.count = SMC_COUNT_ZERO;
      end else begin
        next_st.count = st.count + SMC_COUNT_ONE;
      end
    end

    // single pulse ends on an A match by dropping run
    if (is_pulse & a_hit) begin
      next_st.ctrl_first.counter_run = 1'b0;
    end

    // compare pin: reset on run edge, only A matches move it
    if (run_rise) begin
      next_st.out_changed = 1'b0;
    end else if ((mode == SMC_MODE_COMPARE) & a_hit &
                 (func != SMC_CMP_NOCHG)) begin
      next_st.out_changed = 1'b1;
      next_st.out_level   = cmp_next;
    end

    // registered pin; timer and capture modes do not drive it
    next_st.pin_o  = drive ^ st.control_reg_second.pin_invert;
    next_st.pin_oe = (mode == SMC_MODE_COMPARE) | is_pwm;

    // capture latches the live count
    if (cap_evt) begin
      next_st.capture_value = st.count;
    end

    // sticky flags, a set in the clear cycle wins
    next_st.match_a_flag = (st.match_a_flag & ~flag_clr[0]) | a_hit;
    next_st.match_p_flag = (st.match_p_flag & ~flag_clr[1]) |
                           (p_hit & ~is_pulse &
                            ~(cmp_like &
                              st.control_reg_second.clear_source_sel));
    next_st.capture_flag = (st.capture_flag & ~flag_clr[2]) | cap_evt;

    // bus address phase
    next_st.wr_pend = wr_ok;
    next_st.wr_addr = HADDR[7:0];
    if (ap & ~HWRITE) begin
      next_st.rdata = read_word(st, pin_level, HADDR[7:0]);
    end

    // bus data phase; software write overrides hardware run clear
    if (st.wr_pend) begin
      case (st.wr_addr)
        SMC_OFS_CTRL_FIRST: begin
          next_st.ctrl_first.pause           = HWDATA[7];
          next_st.ctrl_first.counter_run     = HWDATA[3];
          next_st.ctrl_first.compare_p_value = HWDATA[2:0];
        end
        SMC_OFS_CTRL_SECOND: begin
          next_st.control_reg_second = HWDATA[7:0];
        end
        SMC_OFS_COMPARE_A: begin
          next_st.compare_a_value = HWDATA[9:0];
        end
        default: begin
          next_st.wr_pend = wr_ok;  // read-only and unmapped: ignored
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------

  // synchronous reset brings every field to zero
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      st <= SMC_STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------

  // slave never stalls and always answers okay
  assign HREADYOUT       = 1'b1;
  assign HRESP           = SMC_RESP_OKAY;
  assign HRDATA          = st.rdata;
  assign TIMER_IO_PIN_O  = st.pin_o;
  assign TIMER_IO_PIN_OE = st.pin_oe;

endmodule // smc_timer
`default_nettype wire

// ==== testbench/smc_timer_sva.sv ====
/*
  Port-level checker for smc_timer, attached by bind.
  Assumes one master, single word transfers and one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module smc_timer_sva
  import smc_pkg::*;
(
  input wire logic        SYS_CLK,
  input wire logic        RESET,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [2:0]  HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic        HREADYOUT,
  input wire logic [31:0] HRDATA,
  input wire logic        HRESP,
  input wire logic        TIMER_IO_PIN_I,
  input wire logic        TIMER_IO_PIN_O,
  input wire logic        TIMER_IO_PIN_OE
);
  // ----------------------------------------------------------------
  // shadow of the mode/output register
  // ----------------------------------------------------------------
  logic       wr_ph;
  logic [7:0] shd;
  logic [1:0] quiet;
  logic       rd_take;
  assign rd_take = HSEL && HTRANS[1] && HREADY && !HWRITE;
  // quiet saturates at 3 so the registered pin has settled
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      wr_ph <= 1'b0;
      shd   <= 8'h00;
      quiet <= 2'h0;
    end else begin
      wr_ph <= HSEL && HTRANS[1] && HREADY && HWRITE &&
               HSIZE == SMC_HSIZE_WORD && HADDR[7:0] == SMC_OFS_CTRL_SECOND;
      if (wr_ph && HREADY) begin
        shd   <= HWDATA[7:0];
        quiet <= 2'h0;
      end else if (quiet != 2'h3) begin
        quiet <= quiet + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_ready_high: assert property (@(posedge SYS_CLK) disable iff (RESET)
    HREADYOUT) else $error("hreadyout low");
  chk_resp_okay: assert property (@(posedge SYS_CLK) disable iff (RESET)
    !HRESP) else $error("response not okay");
  chk_rdata_hold: assert property (@(posedge SYS_CLK) disable iff (RESET)
    !$past(rd_take) |-> $stable(HRDATA)) else $error("read data moved");
  chk_low_byte: assert property (@(posedge SYS_CLK) disable iff (RESET)
    rd_take && HADDR[7:0] == SMC_OFS_COUNT_LOW |=> HRDATA[31:8] == 24'h00_0000)
    else $error("low byte upper bits set");
  chk_high_byte: assert property (@(posedge SYS_CLK) disable iff (RESET)
    rd_take && HADDR[7:0] == SMC_OFS_COUNT_HIGH |=> HRDATA[31:2] == 30'h0000_0000)
    else $error("high byte upper bits set");
  chk_unmapped_zero: assert property (@(posedge SYS_CLK) disable iff (RESET)
    rd_take && HADDR[7:0] >= 8'h20 |=> HRDATA == SMC_RDATA_ZERO)
    else $error("unmapped read not zero");
  chk_oe_released: assert property (@(posedge SYS_CLK) disable iff (RESET)
    quiet == 2'h3 && shd[6] |-> !TIMER_IO_PIN_OE) else $error("pin driven");
  chk_oe_driven: assert property (@(posedge SYS_CLK) disable iff (RESET)
    quiet == 2'h3 && !shd[6] |-> TIMER_IO_PIN_OE) else $error("pin not driven");
  chk_forced_level: assert property (@(posedge SYS_CLK) disable iff (RESET)
    quiet == 2'h3 && shd[7:6] == SMC_MODE_PWM && !shd[5] |->
    TIMER_IO_PIN_O == (shd[3] ^ shd[2] ^ !shd[4])) else $error("forced level");
endmodule // smc_timer_sva

bind smc_timer smc_timer_sva chk_u (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
  .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP),
  .TIMER_IO_PIN_I(TIMER_IO_PIN_I), .TIMER_IO_PIN_O(TIMER_IO_PIN_O),
  .TIMER_IO_PIN_OE(TIMER_IO_PIN_OE)
);
`default_nettype wire

// ==== testbench/smc_pin_model.sv ====
/*
  Far-side model of the shared timer pin.
  Assumes the bench tells it when to drive and at what level.
*/
`timescale 1ns/1ps
`default_nettype none
module smc_pin_model (
  input  wire logic pin_o,
  input  wire logic pin_oe,
  input  wire logic ext_en,
  input  wire logic ext_lvl,
  output logic      pin_i
);
  // no pull on the pin: once released it shows the inverse of the
  // last driven level, so a stale read-back cannot pass unnoticed
  assign pin_i = pin_oe ? pin_o : (ext_en ? ext_lvl : ~pin_o);
endmodule // smc_pin_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
/*
  Self-checking bench for smc_timer: bus tasks and scenarios.
  Assumes the checker binds itself and the pin model plays the far side.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import smc_pkg::*;
;
  logic        sys_clk;
  logic        reset;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        pin_i;
  logic        pin_o;
  logic        pin_oe;
  logic        ext_en;
  logic        ext_lvl;
  logic [31:0] rd;
  logic [31:0] lo;
  int          n_fail;
  int          tests_run;
  int          cyc = 0;
  int          t0;
  int          hi_n;

  smc_timer dut_u (.SYS_CLK(sys_clk), .RESET(reset), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
    .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout),
    .HRDATA(hrdata), .HRESP(hresp), .TIMER_IO_PIN_I(pin_i),
    .TIMER_IO_PIN_O(pin_o), .TIMER_IO_PIN_OE(pin_oe));
  smc_pin_model pin_u (.pin_o(pin_o), .pin_oe(pin_oe),
    .ext_en(ext_en), .ext_lvl(ext_lvl), .pin_i(pin_i));

  // ----------------------------------------------------------------
  // clock and cycle count
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= cyc + 1;

  // ----------------------------------------------------------------
  // report, compare and bus tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("mismatches %0d of %0d checks", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t word %h not %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t bit %b not %b", $time, got, exp);
    end
  endtask
  // bounded wait for hready; a hang ends the run
  task automatic wait_rdy;
    int i;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1) begin
      n_fail++;
      $display("Error %0t bus hang", $time);
      final_report();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h00_0000, a};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask
  task automatic rdw(input logic [7:0] a);
    bus(1'b0, a, 32'h0000_0000, rd);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    n_fail = 0;
    tests_run = 0;
    reset = 1'b1;
    {hsel, hwrite, ext_en, ext_lvl} = 4'h0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hsize = SMC_HSIZE_WORD;
    hwdata = 32'h0000_0000;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    rdw(SMC_OFS_CTRL_SECOND); chk_word(rd, 32'h0000_0000);
    rdw(SMC_OFS_COUNT_LOW); chk_word(rd, 32'h0000_0000);
    rdw(SMC_OFS_COUNT_HIGH); chk_word(rd, 32'h0000_0000);
    rdw(8'h40); chk_word(rd, 32'h0000_0000);
    wr(SMC_OFS_CTRL_SECOND, 32'h0000_00A5);
    rdw(SMC_OFS_CTRL_SECOND); chk_word(rd, 32'h0000_00A5);
    wr(SMC_OFS_COUNT_LOW, 32'h0000_00FF);
    rdw(SMC_OFS_COUNT_LOW); chk_word(rd, 32'h0000_0000);
    // compare output: every pin action from both initial levels
    wr(SMC_OFS_COMPARE_A, 32'h0000_00C8);
    for (int k = 0; k < 8; k++) begin
      wr(SMC_OFS_CTRL_FIRST, 32'h0000_0001);
      wr(SMC_OFS_CTRL_SECOND, {24'h00_0000, SMC_MODE_COMPARE, k[1:0], k[2], 3'h1});
      wr(SMC_OFS_CTRL_FIRST, 32'h0000_0009);
      repeat (4) @(posedge sys_clk);
      chk_bit(pin_o, k[2]);
      repeat (146) @(posedge sys_clk);
      chk_bit(pin_o, k[2]);
      repeat (60) @(posedge sys_clk);
      chk_bit(pin_o, k[1:0] == 0 ? k[2] : k[1:0] == 3 ? ~k[2] : k[1]);
      rdw(SMC_OFS_COUNT_LOW); chk_bit(rd[7:0] < 8'h14, 1'b1);
    end
    // free count from run rising to run falling, then frozen
    wr(SMC_OFS_CTRL_FIRST, 32'h0000_0000);
    wr(SMC_OFS_CTRL_SECOND, 32'h0000_0000);
    wr(SMC_OFS_CTRL_FIRST, 32'h0000_0008);
    t0 = cyc;
    repeat (300) @(posedge sys_clk);
    wr(SMC_OFS_CTRL_FIRST, 32'h0000_0000);
    t0 = cyc - t0 - 1;
    repeat (20) @(posedge sys_clk);
    rdw(SMC_OFS_COUNT_LOW);
    lo = rd;
    rdw(SMC_OFS_COUNT_HIGH);
    hi_n = int'({rd[1:0], lo[7:0]});
    chk_bit(hi_n >= t0 - 2 && hi_n <= t0 + 2, 1'b1);
    wr(SMC_OFS_CTRL_FIRST, 32'h0000_0008);
    rdw(SMC_OFS_COUNT_LOW); chk_bit(rd[7:0] < 8'h05, 1'b1);
    // p setting zero: counter runs through 1023, wraps to 0 and reads 77 to 81
    repeat (1100) @(posedge sys_clk);
    rdw(SMC_OFS_COUNT_LOW);
    chk_bit(rd[7:0] > 8'h4C && rd[7:0] < 8'h52, 1'b1);
    // timer mode leaves the pin alone
    wr(SMC_OFS_CTRL_FIRST, 32'h0000_0000);
    wr(SMC_OFS_CTRL_SECOND, 32'h0000_00C0);
    repeat (4) @(posedge sys_clk);
    chk_bit(pin_oe, 1'b0);
    // capture edges for every edge selection
    ext_en <= 1'b1;
    for (int f = 0; f < 4; f++) begin
      wr(SMC_OFS_CTRL_FIRST, 32'h0000_0000);
      wr(SMC_OFS_CTRL_SECOND, {24'h00_0000, SMC_MODE_CAPTURE, f[1:0], 4'h0});
      wr(SMC_OFS_CTRL_FIRST, 32'h0000_0008);
      repeat (8) @(posedge sys_clk);
      wr(SMC_OFS_STATUS, 32'h0000_0004);
      ext_lvl <= 1'b1;
      repeat (8) @(posedge sys_clk);
      rdw(SMC_OFS_STATUS); chk_bit(rd[2], f == 0 || f == 2);
      wr(SMC_OFS_STATUS, 32'h0000_0004);
      ext_lvl <= 1'b0;
      repeat (8) @(posedge sys_clk);
      rdw(SMC_OFS_STATUS); chk_bit(rd[2], f == 1 || f == 2);
      chk_bit(pin_oe, 1'b0);
    end
    ext_en <= 1'b0;
    // forced levels over polarity and invert
    wr(SMC_OFS_CTRL_FIRST, 32'h0000_0000);
    for (int k = 0; k < 8; k++) begin
      wr(SMC_OFS_CTRL_SECOND, {24'h00_0000, SMC_MODE_PWM, 1'b0, k[0], k[1], k[2], 2'h0});
      repeat (4) @(posedge sys_clk);
      chk_bit(pin_o, k[1] ^ k[2] ^ ~k[0]);
    end
    // waveform with period and duty swapped between comparators
    wr(SMC_OFS_COMPARE_A, 32'h0000_0020);
    for (int s = 0; s < 2; s++) begin
      wr(SMC_OFS_CTRL_FIRST, 32'h0000_0001);
      // clear source set: the pwm period must ignore it
      wr(SMC_OFS_CTRL_SECOND, {24'h00_0000, SMC_MODE_PWM, SMC_PWM_WAVE,
                               2'h2, s[0], 1'b1});
      wr(SMC_OFS_CTRL_FIRST, 32'h0000_0009);
      repeat (20) @(posedge sys_clk);
      hi_n = 0;
      repeat (128) begin
        @(posedge sys_clk);
        hi_n += (pin_o === 1'b1) ? 1 : 0;
      end
      chk_bit(s == 0 ? (hi_n >= 30 && hi_n <= 34) : hi_n >= 124, 1'b1);
    end
    final_report();
  end
endmodule // tb_top
`default_nettype wire
